// *** verilog/uart_irq_sleep_ctrl.sv ***
`timescale 1ns/1ps

module uart_irq_sleep_ctrl #(
  parameter logic [1:0] CHAN_CODE = uart_irq_pkg::CHAN_A  // Channel this block answers
) (
  input  wire logic                   mclk_i,          // UART clock, 50 MHz
  input  wire logic                   reset_n_i,       // Asynchronous reset, active low
  input  wire uart_irq_pkg::reg_req_t reg_req_i,       // Register access request
  input  wire logic [7:0]             line_control_i,  // Line control register value
  input  wire logic                   enh_enable_i,    // Enhanced feature reg bit 4
  input  wire logic                   fifo_enable_i,   // FIFO control reg FIFO enable
  input  wire uart_irq_pkg::irq_src_t irq_src_i,       // Interrupt sources
  input  wire logic                   tx_fifo_empty_i, // Transmit FIFO empty
  input  wire logic                   rx_fifo_empty_i, // Receive FIFO empty
  input  wire logic                   tx_fifo_wr_i,    // Byte written to transmit FIFO
  input  wire logic                   cts_n_i,         // CTS pin, asynchronous
  input  wire logic                   dsr_n_i,         // DSR pin, asynchronous
  input  wire logic                   rx_pin_i,        // Receive pin, asynchronous
  output logic [7:0]                  rdata_o,         // Read data
  output logic                        rvalid_o,        // Read data valid pulse
  output logic [7:0]                  int_enable_o,    // Interrupt enable register
  output logic [7:0]                  div_high_o,      // Baud divisor high byte
  output logic                        irq_o,           // Interrupt request, active high
  output logic                        osc_enable_o,    // Crystal oscillator enable
  output logic                        uart_clk_en_o,   // Channel clock gate enable
  output logic                        sleeping_o       // Channel in sleep
);
  import uart_irq_pkg::*;

  // Pin synchronisers and change detection
  logic [2:0] cts_sync_r;
  logic [2:0] dsr_sync_r;
  logic [1:0] rx_sync_r;
  logic       cts_toggle;
  logic       dsr_toggle;
  logic       modem_toggle;
  logic       cts_inactive;

  // Register state
  logic [7:0] int_enable_r;
  logic [7:0] div_high_r;
  logic [7:0] ident;
  logic [7:0] rdata_r;
  logic       rvalid_r;

  // Sticky event flags
  logic       pin_chg_r;
  logic       xoff_r;
  logic       special_r;
  logic       inactive_r;

  // Decode and priority
  logic       chan_hit;
  logic       bank0;
  logic       ie_wr;
  logic       dh_wr;
  logic       id_rd;
  logic [5:0] code;
  logic       pending;
  logic       tx_ready;

  // Enabled level sources and sticky flag set events
  logic       line_on;
  logic       tmo_on;
  logic       rxd_on;
  logic       txr_on;
  logic       mdm_on;
  logic       pin_set;
  logic       inact_set;
  logic       xoff_set;
  logic       spec_set;

  pwr_state_t pwr_r;
  pwr_state_t pwr_nxt;
  logic       sleep_ok;
  logic       wake;

  // Register hit for one index in the normal bank
  function automatic logic bank0_hit(input logic [3:0] idx, input logic [3:0] want,
                                     input logic [7:0] line_control_reg);
    bank0_hit = (idx == want) && !line_control_reg[LCR_BANK_BIT];
  endfunction

  // Two flip-flop synchronisers, plus a history stage for edges on CTS and DSR only
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cts_sync_r <= 3'h7;
      dsr_sync_r <= 3'h7;
      rx_sync_r  <= 2'h3;
    end else begin
      cts_sync_r <= {cts_sync_r[1:0], cts_n_i};
      dsr_sync_r <= {dsr_sync_r[1:0], dsr_n_i};
      rx_sync_r  <= {rx_sync_r[0], rx_pin_i};
    end
  end

  // Modem edges seen on the synchronised stages only
  assign cts_toggle   = cts_sync_r[2] ^ cts_sync_r[1];
  assign dsr_toggle   = dsr_sync_r[2] ^ dsr_sync_r[1];
  assign modem_toggle = cts_toggle | dsr_toggle;
  assign cts_inactive = !cts_sync_r[2] && cts_sync_r[1];  // Low active goes high

  // Address decode for this channel
  assign chan_hit = (reg_req_i.chan == CHAN_CODE);
  assign bank0    = bank0_hit(reg_req_i.idx, IDX_INT_ENABLE, line_control_i);
  assign ie_wr    = reg_req_i.wr && chan_hit && bank0;
  assign id_rd    = reg_req_i.rd && chan_hit
                    && bank0_hit(reg_req_i.idx, IDX_INT_IDENT, line_control_i);
  assign dh_wr    = reg_req_i.wr && chan_hit && (reg_req_i.idx == IDX_DIV_HIGH)
                    && line_control_i[LCR_BANK_BIT] && (line_control_i != LCR_EFR_KEY);

  // Interrupt enable register, upper nibble guarded by enhanced enable
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_enable_r <= RST_INT_ENABLE;
    end else if (ie_wr) begin
      if (enh_enable_i) begin
        int_enable_r <= reg_req_i.wdata;
      end else begin
        int_enable_r <= (int_enable_r & ~IE_BASIC_MASK)
                        | (reg_req_i.wdata & IE_BASIC_MASK);
      end
    end
  end

  // Baud divisor high byte
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_high_r <= RST_DIV_HIGH;
    end else if (dh_wr) begin
      div_high_r <= reg_req_i.wdata;
    end
  end

  // Flag set events, gated by their enable bits
  assign pin_set   = (modem_toggle && int_enable_r[IE_CTS_DSR])
                     || (irq_src_i.rts_dtr_chg && int_enable_r[IE_RTS_DTR]);
  assign inact_set = (cts_inactive && int_enable_r[IE_CTS_DSR])
                     || (irq_src_i.rts_inactive && int_enable_r[IE_RTS_DTR]);
  assign xoff_set  = irq_src_i.xoff_rx && int_enable_r[IE_SW_FLOW];
  assign spec_set  = irq_src_i.special_rx && int_enable_r[IE_SW_FLOW];

  // Input pin change flag; a new event beats the read clear
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_chg_r <= 1'b0;
    end else if (pin_set) begin
      pin_chg_r <= 1'b1;
    end else if (id_rd && code == ID_PIN_CHANGE) begin
      pin_chg_r <= 1'b0;
    end
  end

  // Xoff flag, cleared by Xon
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xoff_r <= 1'b0;
    end else if (xoff_set) begin
      xoff_r <= 1'b1;
    end else if (irq_src_i.xon_rx) begin
      xoff_r <= 1'b0;
    end
  end

  // Special character flag, cleared by an ident read
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      special_r <= 1'b0;
    end else if (spec_set) begin
      special_r <= 1'b1;
    end else if (id_rd) begin
      special_r <= 1'b0;
    end
  end

  // CTS or RTS active-to-inactive flag, cleared by reading it
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inactive_r <= 1'b0;
    end else if (inact_set) begin
      inactive_r <= 1'b1;
    end else if (id_rd && code == ID_INACTIVE) begin
      inactive_r <= 1'b0;
    end
  end

  // Transmit ready depends on FIFO mode
  assign tx_ready = fifo_enable_i ? irq_src_i.tx_space : irq_src_i.thr_empty;

  // Level sources masked by their enable bits
  assign line_on = irq_src_i.line_err && int_enable_r[IE_LINE_STAT];
  assign tmo_on  = irq_src_i.rx_timeout && int_enable_r[IE_RX_DATA];
  assign rxd_on  = irq_src_i.rx_ready && int_enable_r[IE_RX_DATA];
  assign txr_on  = tx_ready && int_enable_r[IE_TX_READY];
  assign mdm_on  = irq_src_i.modem_stat && int_enable_r[IE_MODEM];

  // Priority encoder over enabled sources
  always_comb begin
    pending = 1'b1;
    if (line_on) begin
      code = ID_LINE_STAT;
    end else if (tmo_on) begin
      code = ID_RX_TIMEOUT;
    end else if (rxd_on) begin
      code = ID_RX_DATA;
    end else if (txr_on) begin
      code = ID_TX_READY;
    end else if (mdm_on) begin
      code = ID_MODEM;
    end else if (pin_chg_r) begin
      code = ID_PIN_CHANGE;
    end else if (xoff_r || special_r) begin
      code = ID_SW_FLOW;
    end else if (inactive_r) begin
      code = ID_INACTIVE;
    end else begin
      pending = 1'b0;
      code    = ID_NO_PEND;
    end
  end

  // Ident value: FIFO mirror, source code, pending bit
  always_comb begin
    ident                       = {2'b00, code};
    ident[ID_FIFO_LO]           = fifo_enable_i;
    ident[ID_FIFO_HI]           = fifo_enable_i;
    ident[ID_NONE_BIT]          = !pending;
  end

  // Registered read data; unmapped reads give zero
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_req_i.rd && chan_hit;
      if (reg_req_i.rd && chan_hit) begin
        if (id_rd) begin
          rdata_r <= ident;
        end else if (reg_req_i.idx == IDX_INT_ENABLE && !line_control_i[LCR_BANK_BIT]) begin
          rdata_r <= int_enable_r;
        end else if (reg_req_i.idx == IDX_DIV_HIGH && line_control_i != LCR_EFR_KEY) begin
          rdata_r <= div_high_r;
        end else begin
          rdata_r <= 8'h00;
        end
      end
    end
  end

  // Sleep entry and wake conditions
  assign sleep_ok = int_enable_r[IE_SLEEP] && enh_enable_i
                    && !pending && !modem_toggle && rx_sync_r[1]
                    && tx_fifo_empty_i && rx_fifo_empty_i && !tx_fifo_wr_i;
  assign wake     = modem_toggle || !rx_sync_r[1] || tx_fifo_wr_i;

  // Sleep state next value
  always_comb begin
    case (pwr_r)
      PWR_RUN: begin
        pwr_nxt = sleep_ok ? PWR_SLEEP : PWR_RUN;
      end
      PWR_SLEEP: begin
        pwr_nxt = wake ? PWR_RUN : PWR_SLEEP;
      end
      default: begin
        pwr_nxt = PWR_RUN;
      end
    endcase
  end

  // Sleep state register
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwr_r <= PWR_RUN;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Registered interrupt and clock controls
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o         <= 1'b0;
      osc_enable_o  <= 1'b1;
      uart_clk_en_o <= 1'b1;
      sleeping_o    <= 1'b0;
    end else begin
      irq_o         <= pending;
      osc_enable_o  <= (pwr_nxt != PWR_SLEEP);
      uart_clk_en_o <= (pwr_nxt != PWR_SLEEP);
      sleeping_o    <= (pwr_nxt == PWR_SLEEP);
    end
  end

  assign rdata_o      = rdata_r;
  assign rvalid_o     = rvalid_r;
  assign int_enable_o = int_enable_r;
  assign div_high_o   = div_high_r;

endmodule

// *** pkg/uart_irq_pkg.sv ***
package uart_irq_pkg;

  // Register indices as carried in address byte bits 6:3
  localparam logic [3:0] IDX_INT_ENABLE = 4'h1;
  localparam logic [3:0] IDX_INT_IDENT  = 4'h2;
  localparam logic [3:0] IDX_DIV_HIGH   = 4'h1;

  // Channel select codes carried in address byte bits 2:1
  localparam logic [1:0] CHAN_A = 2'h0;
  localparam logic [1:0] CHAN_B = 2'h1;

  // Line control bank bit and the enhanced bank key
  localparam int         LCR_BANK_BIT = 7;
  localparam logic [7:0] LCR_EFR_KEY  = 8'hBF;

  // Interrupt enable fields
  localparam int IE_RX_DATA   = 0;
  localparam int IE_TX_READY  = 1;
  localparam int IE_LINE_STAT = 2;
  localparam int IE_MODEM     = 3;
  localparam int IE_SLEEP     = 4;
  localparam int IE_SW_FLOW   = 5;
  localparam int IE_RTS_DTR   = 6;
  localparam int IE_CTS_DSR   = 7;
  localparam logic [7:0] IE_BASIC_MASK = 8'h0F;

  // Identification fields and codes for bits 5:0
  localparam int         ID_NONE_BIT   = 0;
  localparam int         ID_FIFO_LO    = 6;
  localparam int         ID_FIFO_HI    = 7;
  localparam logic [5:0] ID_LINE_STAT  = 6'h06;
  localparam logic [5:0] ID_RX_TIMEOUT = 6'h0C;
  localparam logic [5:0] ID_RX_DATA    = 6'h04;
  localparam logic [5:0] ID_TX_READY   = 6'h02;
  localparam logic [5:0] ID_MODEM      = 6'h00;
  localparam logic [5:0] ID_PIN_CHANGE = 6'h30;
  localparam logic [5:0] ID_SW_FLOW    = 6'h10;
  localparam logic [5:0] ID_INACTIVE   = 6'h20;
  localparam logic [5:0] ID_NO_PEND    = 6'h01;

  // Reset values
  localparam logic [7:0] RST_INT_ENABLE = 8'h00;
  localparam logic [7:0] RST_INT_IDENT  = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH   = 8'h00;

  // Register access from the serial front end
  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [3:0] idx;    // Register index
    logic [1:0] chan;   // Channel select
    logic [7:0] wdata;  // Write data
  } reg_req_t;

  // Interrupt conditions and events from the channel datapath
  typedef struct packed {
    logic line_err;      // Receiver line status error, level
    logic rx_timeout;    // Receiver timeout, level
    logic rx_ready;      // Receive data ready, level
    logic thr_empty;     // Holding register empty (non-FIFO), level
    logic tx_space;      // FIFO space above trigger, level
    logic modem_stat;    // Modem status change pending, level
    logic rts_dtr_chg;   // RTS or DTR changed state, pulse
    logic rts_inactive;  // RTS went active to inactive, pulse
    logic xoff_rx;       // Xoff received, pulse
    logic xon_rx;        // Xon received, pulse
    logic special_rx;    // Special character seen, pulse
  } irq_src_t;

  // Sleep gate state
  typedef enum logic [1:0] {
    PWR_RUN   = 2'b01,
    PWR_SLEEP = 2'b10
  } pwr_state_t;

endpackage

// *** verification/uart_irq_chk.sv ***
`timescale 1ns/1ps
module uart_irq_chk #(
  parameter logic [1:0] CHAN_CODE = uart_irq_pkg::CHAN_A  // Channel watched
) (
  input wire logic                   mclk_i,          // Clock
  input wire logic                   reset_n_i,       // Reset, active low
  input wire uart_irq_pkg::reg_req_t reg_req_i,       // Request
  input wire logic [7:0]             line_control_i,  // Line control
  input wire logic                   enh_enable_i,    // Enhanced enable
  input wire logic                   fifo_enable_i,   // FIFO enable
  input wire uart_irq_pkg::irq_src_t irq_src_i,       // Sources
  input wire logic                   tx_fifo_empty_i, // TX empty
  input wire logic                   rx_fifo_empty_i, // RX empty
  input wire logic                   tx_fifo_wr_i,    // TX write
  input wire logic                   cts_n_i,         // CTS pin
  input wire logic                   dsr_n_i,         // DSR pin
  input wire logic                   rx_pin_i,        // RX pin
  input wire logic [7:0]             rdata_o,         // Read data
  input wire logic                   rvalid_o,        // Read valid
  input wire logic [7:0]             int_enable_o,    // Enable register
  input wire logic [7:0]             div_high_o,      // Divisor high
  input wire logic                   irq_o,           // Interrupt
  input wire logic                   osc_enable_o,    // Oscillator on
  input wire logic                   uart_clk_en_o,   // Clock gate
  input wire logic                   sleeping_o       // Asleep
);
  import uart_irq_pkg::*;
  logic take_rd;
  logic ie_wr;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Decoded accesses of this channel
  assign take_rd = reg_req_i.rd && reg_req_i.chan == CHAN_CODE;
  assign ie_wr = reg_req_i.wr && reg_req_i.chan == CHAN_CODE &&
                 reg_req_i.idx == IDX_INT_ENABLE && !line_control_i[LCR_BANK_BIT];
  a_read_answer: assert property (take_rd |=> rvalid_o)
    else $error("read not answered");
  a_read_refuse: assert property (!take_rd |=> !rvalid_o)
    else $error("unexpected read valid");
  a_ie_write: assert property (ie_wr |=> int_enable_o[3:0] == $past(reg_req_i.wdata[3:0]))
    else $error("enable low bits not written");
  a_ie_lock: assert property (ie_wr && !enh_enable_i |=> $stable(int_enable_o[7:4]))
    else $error("enable high bits changed while locked");
  a_ie_bank: assert property (line_control_i[LCR_BANK_BIT] |=> $stable(int_enable_o))
    else $error("enable changed in upper bank");
  a_sleep_gate: assert property ($rose(sleeping_o) |-> $past(int_enable_o[IE_SLEEP] && enh_enable_i))
    else $error("sleep without enable");
  a_sleep_entry: assert property ($rose(sleeping_o) |->
    $past(tx_fifo_empty_i && rx_fifo_empty_i && !tx_fifo_wr_i))
    else $error("sleep with busy FIFO");
  a_sleep_clock: assert property (osc_enable_o == !sleeping_o && uart_clk_en_o == !sleeping_o)
    else $error("clock enables disagree with sleep");
  a_sleep_wake: assert property (sleeping_o && tx_fifo_wr_i |=> !sleeping_o)
    else $error("no wake on transmit write");
  a_rx_irq: assert property (int_enable_o[IE_RX_DATA] && irq_src_i.rx_ready && !reg_req_i.wr
    |=> irq_o)
    else $error("data ready did not interrupt");
  a_line_irq: assert property (int_enable_o[IE_LINE_STAT] && irq_src_i.line_err && !reg_req_i.wr
    |=> irq_o)
    else $error("line error did not interrupt");
  // Main scenarios reached
  c_sleep: cover property ($rose(sleeping_o));
  c_irq: cover property ($rose(irq_o));
  c_read: cover property (rvalid_o);
endmodule
bind uart_irq_sleep_ctrl uart_irq_chk #(.CHAN_CODE(CHAN_CODE)) i_uart_irq_chk (.*);

// *** verification/uart_host_model.sv ***
`timescale 1ns/1ps
module uart_host_model (
  input  wire logic              mclk_i,   // Clock
  input  wire logic              rvalid_i, // Read valid
  input  wire logic [7:0]        rdata_i,  // Read data
  output uart_irq_pkg::reg_req_t req_o     // Request
);
  import uart_irq_pkg::*;
  logic [1:0] chan_sel = CHAN_A;  // Channel of next access
  initial req_o = '0;
  // One-cycle write strobe
  task automatic write_reg(input logic [3:0] idx, input logic [7:0] d);
    @(posedge mclk_i);
    #1 req_o = '{wr: 1'b1, rd: 1'b0, idx: idx, chan: chan_sel, wdata: d};
    @(posedge mclk_i);
    #1 req_o = '0;
  endtask
  // One-cycle read strobe, answer taken once settled
  task automatic read_reg(input logic [3:0] idx, output logic [7:0] d, output logic v);
    @(posedge mclk_i);
    #1 req_o = '{wr: 1'b0, rd: 1'b1, idx: idx, chan: chan_sel, wdata: 8'h00};
    @(posedge mclk_i);
    #1 d = rdata_i;
    v = rvalid_i;
    req_o = '0;
  endtask
endmodule

// *** verification/uart_interrupt_sleep_control_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) check_val(8'(g), 8'(e))
module uart_interrupt_sleep_control_tb;
  import uart_irq_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] line_control_reg = 8'h00;
  logic enh = 1'b0, fifo_en = 1'b0, tx_wr = 1'b0, cts_n = 1'b1, rx_pin = 1'b1;
  logic dsr_n = 1'b1;
  logic tx_empty = 1'b1, rx_empty = 1'b1;
  irq_src_t src = '0;
  reg_req_t req;
  logic [7:0] rdata, ie, div_h, w, d, x;
  logic rvalid, irq, osc_en, clk_en, sleeping, v;
  int error_cnt = 0, checks = 0, cyc = 0;
  uart_irq_sleep_ctrl i_uart_irq_sleep_ctrl (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .reg_req_i(req), .line_control_i(line_control_reg), .enh_enable_i(enh), .fifo_enable_i(fifo_en),
    .irq_src_i(src), .tx_fifo_empty_i(tx_empty), .rx_fifo_empty_i(rx_empty),
    .tx_fifo_wr_i(tx_wr), .cts_n_i(cts_n), .dsr_n_i(dsr_n), .rx_pin_i(rx_pin),
    .rdata_o(rdata), .rvalid_o(rvalid), .int_enable_o(ie), .div_high_o(div_h), .irq_o(irq),
    .osc_enable_o(osc_en), .uart_clk_en_o(clk_en), .sleeping_o(sleeping));
  uart_host_model i_uart_host_model (.mclk_i(mclk_i), .rvalid_i(rvalid), .rdata_i(rdata),
    .req_o(req));
  // Expected identification from enabled levels, highest priority last
  function automatic logic [7:0] exp_id(irq_src_t s, logic [3:0] e, logic f);
    logic [5:0] c;
    c = ID_NO_PEND;
    if (e[IE_MODEM] && s.modem_stat) c = ID_MODEM;
    if (e[IE_TX_READY] && (f ? s.tx_space : s.thr_empty)) c = ID_TX_READY;
    if (e[IE_RX_DATA] && s.rx_ready) c = ID_RX_DATA;
    if (e[IE_RX_DATA] && s.rx_timeout) c = ID_RX_TIMEOUT;
    if (e[IE_LINE_STAT] && s.line_err) c = ID_LINE_STAT;
    return {f, f, c};
  endfunction
  task automatic check_val(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Reads identification and compares it
  task automatic rd_id(input logic [7:0] e);
    i_uart_host_model.read_reg(IDX_INT_IDENT, d, v);
    `CHK(v, 1'b1);
    `CHK(d, e);
  endtask
  // One-cycle event pulse: xoff, special, rts/dtr, inactive, xon
  task automatic pulse_src(input int k);
    case (k)
      0: src.xoff_rx = 1'b1;
      1: src.special_rx = 1'b1;
      2: src.rts_dtr_chg = 1'b1;
      3: src.rts_inactive = 1'b1;
      default: src.xon_rx = 1'b1;
    endcase
    tick(1);
    src = '0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  // Hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(86));
    tick(3);
    reset_n_i = 1'b1;
    `CHK(ie, RST_INT_ENABLE);
    `CHK(div_h, RST_DIV_HIGH);
    `CHK(osc_en, 1'b1);
    rd_id(8'h01);
    fifo_en = 1'b1;
    rd_id(8'hC1);
    i_uart_host_model.chan_sel = CHAN_B;
    i_uart_host_model.read_reg(IDX_INT_IDENT, d, v);
    `CHK(v, 1'b0);
    i_uart_host_model.chan_sel = CHAN_A;
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 8'hFF : 8'($urandom);
      fifo_en = 1'($urandom);
      {src.line_err, src.rx_timeout, src.rx_ready, src.thr_empty, src.tx_space,
       src.modem_stat} = (i == 0) ? 6'h3F : 6'($urandom);
      i_uart_host_model.write_reg(IDX_INT_ENABLE, w);
      tick(2);
      `CHK(ie, {4'h0, w[3:0]});
      x = exp_id(src, w[3:0], fifo_en);
      rd_id(x);
      `CHK(irq, !x[ID_NONE_BIT]);
    end
    src = '0;
    fifo_en = 1'b0;
    line_control_reg = 8'h80;
    i_uart_host_model.write_reg(IDX_DIV_HIGH, ~w);
    tick(1);
    `CHK(div_h, ~w);
    `CHK(ie, {4'h0, w[3:0]});
    line_control_reg = 8'h00;
    $display("test priority done");
    enh = 1'b1;
    i_uart_host_model.write_reg(IDX_INT_ENABLE, 8'hE0);
    tick(1);
    `CHK(ie, 8'hE0);
    for (int k = 0; k < 4; k++) begin
      pulse_src(k);
      tick(3);
      `CHK(irq, 1'b1);
      x = {2'b00, (k < 2) ? ID_SW_FLOW : (k == 2) ? ID_PIN_CHANGE : ID_INACTIVE};
      rd_id(x);
      if (k == 0) begin
        rd_id({2'b00, ID_SW_FLOW});
        pulse_src(4);
        tick(3);
      end
      rd_id(8'h01);
    end
    cts_n = 1'b0;
    tick(8);
    rd_id({2'b00, ID_PIN_CHANGE});
    rd_id(8'h01);
    cts_n = 1'b1;
    tick(8);
    rd_id({2'b00, ID_PIN_CHANGE});
    rd_id({2'b00, ID_INACTIVE});
    dsr_n = 1'b0;
    tick(8);
    rd_id({2'b00, ID_PIN_CHANGE});
    dsr_n = 1'b1;
    tick(8);
    rd_id({2'b00, ID_PIN_CHANGE});
    rd_id(8'h01);
    i_uart_host_model.write_reg(IDX_INT_ENABLE, 8'h00);
    pulse_src(0);
    tick(3);
    `CHK(irq, 1'b0);
    pulse_src(4);
    $display("test events done");
    i_uart_host_model.write_reg(IDX_INT_ENABLE, 8'h10);
    tick(4);
    `CHK(sleeping, 1'b1);
    `CHK({osc_en, clk_en}, 2'b00);
    tx_wr = 1'b1;
    tick(1);
    tx_wr = 1'b0;
    `CHK(sleeping, 1'b0);
    tick(4);
    `CHK(sleeping, 1'b1);
    rx_pin = 1'b0;
    tick(6);
    `CHK(sleeping, 1'b0);
    rx_pin = 1'b1;
    enh = 1'b0;
    tick(6);
    `CHK(sleeping, 1'b0);
    enh = 1'b1;
    rx_empty = 1'b0;
    tick(6);
    `CHK(sleeping, 1'b0);
    $display("test sleep done");
    give_verdict();
  end
endmodule
